// File: bench/scfg_host.sv
// Host controller model driving the serial port
`timescale 1ns/1ns
module scfg_host (
   output logic sclk,
   output logic cs_b,
   output logic sdi,
   input wire logic dout_o,
   input wire logic dout_oe
);
   logic junk;
   logic pin;
   // Released pin shows a changing pattern, never the last bit
   assign pin = dout_oe ? dout_o : junk;
   // Clock idles high and stands still between frames
   initial begin
      sclk = 1'b1;
      cs_b = 1'b1;
      sdi = 1'b0;
      junk = 1'b0;
   end
   // One frame of n edges, MSB first, sampled on rising sclk
   task automatic xfer(input int n, input logic [31:0] tx, input bit raise,
      output logic [31:0] rx);
      rx = 32'h0;
      cs_b = 1'b0;
      #40;
      for (int i = n - 1; i >= 0; i--) begin
         #32 sclk = 1'b0;
         sdi = tx[i];
         #32 sclk = 1'b1;
         rx = {rx[30:0], pin};
         junk = ~junk;
      end
      #40;
      sdi = ~sdi;
      if (raise) begin
         cs_b = 1'b1;
      end
   endtask
   // Select moved alone between frames, to look at the ready level on the pin
   task automatic hold_cs(input logic level);
      cs_b = level;
   endtask
endmodule // scfg_host

// File: bench/scfg_props.sv
// Checker of the serial configuration block ports
`timescale 1ns/1ns
module scfg_props (
   input wire logic clk,
   input wire logic rst_b,
   input wire logic sclk,
   input wire logic cs_b,
   input wire logic sdi,
   input wire logic conv_ready,
   input wire logic [15:0] conv_data,
   input wire logic [7:0] conv_status,
   input wire logic drdy_route_dout,
   input wire logic dout_o,
   input wire logic dout_oe,
   input wire logic drdy_alert_b,
   input wire logic [15:0] ctrl_o,
   input wire logic int_ref_on,
   input wire logic ref_level_low
);
   default clocking cb @(posedge clk); endclocking
   default disable iff (!rst_b);
   logic [2:0] hi_cnt;
   // Idle-high samples; a running bit clock never gives seven in a row
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         hi_cnt <= 3'h0;
      end else if (!sclk) begin
         hi_cnt <= 3'h0;
      end else if (hi_cnt != 3'h7) begin
         hi_cnt <= hi_cnt + 3'h1;
      end
   end
   oe_cs_high_a: assert property (cs_b && $past(cs_b) |-> !dout_oe)
      else $error("output driven while chip select high");
   oe_start_a: assert property ($rose(dout_oe) |-> !cs_b && !$past(cs_b))
      else $error("output enabled outside a frame");
   idle_4w_a: assert property ($rose(cs_b) && ctrl_o[9] |=> !dout_oe [*4])
      else $error("output not released after chip select rise");
   release_3w_a: assert property (hi_cnt == 3'h7 && !ctrl_o[9] && !drdy_route_dout
      |-> !dout_oe)
      else $error("three wire output not released after frame");
   ref_on_a: assert property ($rose(ctrl_o[8]) |-> ##[0:2] int_ref_on)
      else $error("reference not switched on");
   ref_level_a: assert property ($stable(ctrl_o) [*2] |->
      ref_level_low == (ctrl_o[8] && ctrl_o[13]) && int_ref_on == ctrl_o[8])
      else $error("reference outputs disagree with control");
   alert_route_a: assert property (drdy_route_dout && $past(drdy_route_dout) |-> drdy_alert_b)
      else $error("alert pin active while ready routed to output");
   alert_ready_a: assert property (conv_ready && !drdy_route_dout |-> ##[1:4] !drdy_alert_b)
      else $error("alert pin missed new result");
   cover property (dout_oe && ctrl_o[10]);
   cover property ($rose(cs_b) && ctrl_o[9]);
   cover property ($fell(dout_oe) && !cs_b);
endmodule // scfg_props

bind scfg_top scfg_props scfg_props_i (.clk(clk), .rst_b(rst_b), .sclk(sclk), .cs_b(cs_b),
   .sdi(sdi), .conv_ready(conv_ready), .conv_data(conv_data), .conv_status(conv_status),
   .drdy_route_dout(drdy_route_dout), .dout_o(dout_o), .dout_oe(dout_oe),
   .drdy_alert_b(drdy_alert_b), .ctrl_o(ctrl_o), .int_ref_on(int_ref_on),
   .ref_level_low(ref_level_low));

// File: bench/spi_wire_mode_status_append_tb.sv
// Testbench of the serial configuration block
`timescale 1ns/1ns
module spi_wire_mode_status_append_tb;
   logic clk, rst_b, sclk, cs_b, sdi, conv_ready, drdy_route_dout;
   logic [15:0] conv_data;
   logic [7:0] conv_status;
   logic dout_o, dout_oe, drdy_alert_b, int_ref_on, ref_level_low;
   logic [15:0] ctrl_o;
   logic [31:0] rx;
   int fails;
   int total_checks;

   scfg_top scfg_top_i (.clk(clk), .rst_b(rst_b), .sclk(sclk), .cs_b(cs_b), .sdi(sdi),
      .conv_ready(conv_ready), .conv_data(conv_data), .conv_status(conv_status),
      .drdy_route_dout(drdy_route_dout), .dout_o(dout_o), .dout_oe(dout_oe),
      .drdy_alert_b(drdy_alert_b), .ctrl_o(ctrl_o), .int_ref_on(int_ref_on),
      .ref_level_low(ref_level_low));
   scfg_host scfg_host_i (.sclk(sclk), .cs_b(cs_b), .sdi(sdi), .dout_o(dout_o),
      .dout_oe(dout_oe));

   // 20 MHz system clock
   initial clk = 1'b0;
   always #25 clk = ~clk;

   task automatic stop_test;
      $display("checks %0d mismatches %0d", total_checks, fails);
      if (fails == 0 && total_checks > 0) begin
         $display("Finished cleanly");
      end else begin
         $display("Finished with errors");
      end
      $finish;
   endtask

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      total_checks++;
      if (got !== exp) begin
         fails++;
         $display("mismatch at %0t: got %h expected %h", $time, got, exp);
      end
   endtask

   task automatic cyc(input int n);
      repeat (n) @(negedge clk);
   endtask

   // Write frame: command byte then 16 data bits
   task automatic wr(input logic [5:0] a, input logic [15:0] v, input bit raise);
      scfg_host_i.xfer(24, {8'h00, 2'b00, a, v}, raise, rx);
      cyc(8);
   endtask

   // Read frame of n edges; command sits in the first eight
   task automatic rd(input logic [5:0] a, input int n, input bit raise);
      scfg_host_i.xfer(n, {24'h0, 2'b01, a} << (n - 8), raise, rx);
      cyc(8);
   endtask

   // New result; bounded wait for the alert level that the routing asks for
   task automatic result(input logic [15:0] d, input logic [7:0] s);
      int k;
      conv_data = d;
      conv_status = s;
      conv_ready = 1'b1;
      cyc(1);
      conv_ready = 1'b0;
      // Routed to the output pin, the alert pin must stay high instead
      for (k = 0; k < 20 && drdy_alert_b !== drdy_route_dout; k++) begin
         cyc(1);
      end
      chk(32'(drdy_alert_b), 32'(drdy_route_dout));
      if (drdy_alert_b !== drdy_route_dout) begin
         stop_test();
      end
   endtask

   task automatic t_reset;
      chk(32'(ctrl_o), 32'h0);
      chk(32'(int_ref_on), 32'h0);
      chk(32'(dout_oe), 32'h0);
      chk(32'(drdy_alert_b), 32'h1);
      $display("test reset done");
   endtask

   // Three wire: reserved bit dropped, reference bits reach their pins
   task automatic t_three_wire;
      wr(scfg_pkg::ADDR_CONTROL, 16'h2580, 1'b0);
      chk(32'(ctrl_o), 32'h2500);
      chk(32'(int_ref_on), 32'h1);
      chk(32'(ref_level_low), 32'h1);
      rd(scfg_pkg::ADDR_CONTROL, 24, 1'b0);
      chk(32'(rx[15:0]), 32'h2500);
      chk(32'(dout_oe), 32'h0);
      $display("test three wire done");
   endtask

   // Status byte follows the result only while append is set
   task automatic t_append;
      result(16'hbeef, 8'h5a);
      rd(scfg_pkg::ADDR_DATA, 32, 1'b0);
      chk(32'(rx[23:0]), 32'hbeef5a);
      chk(32'(dout_oe), 32'h0);
      wr(scfg_pkg::ADDR_CONTROL, 16'h1100, 1'b0);
      chk(32'(ref_level_low), 32'h0);
      result(16'h1234, 8'ha5);
      rd(scfg_pkg::ADDR_DATA, 24, 1'b0);
      chk(32'(rx[15:0]), 32'h1234);
      chk(32'(dout_oe), 32'h0);
      rd(scfg_pkg::ADDR_STATUS, 16, 1'b0);
      chk(32'(rx[7:0]), 32'ha5);
      rd(6'h05, 16, 1'b0);
      chk(32'(rx[7:0]), 32'h0);
      $display("test append done");
   endtask

   // Four wire: ready on the pin, abort on chip select rise, faults only here
   task automatic t_four_wire;
      wr(scfg_pkg::ADDR_CONTROL, 16'h0200, 1'b1);
      chk(32'(ctrl_o), 32'h0200);
      rd(scfg_pkg::ADDR_FAULT, 16, 1'b1);
      chk(32'(rx[7:0]), 32'h0);
      drdy_route_dout = 1'b1;
      result(16'h0f0f, 8'h11);
      cyc(2);
      chk(32'(drdy_alert_b), 32'h1);
      scfg_host_i.hold_cs(1'b0);
      cyc(6);
      chk(32'(dout_oe), 32'h1);
      chk(32'(dout_o), 32'h0);
      scfg_host_i.hold_cs(1'b1);
      cyc(4);
      chk(32'(dout_oe), 32'h0);
      wr(scfg_pkg::ADDR_STATUS, 16'h00ff, 1'b1);
      scfg_host_i.xfer(12, 32'({2'b01, scfg_pkg::ADDR_CONTROL, 4'h0}), 1'b1, rx);
      cyc(8);
      chk(32'(dout_oe), 32'h0);
      rd(6'h05, 16, 1'b1);
      rd(scfg_pkg::ADDR_FAULT, 16, 1'b1);
      chk(32'(rx[7:0]), 32'h07);
      rd(scfg_pkg::ADDR_CONTROL, 24, 1'b1);
      chk(32'(rx[15:0]), 32'h0200);
      rd(scfg_pkg::ADDR_FAULT, 16, 1'b1);
      chk(32'(rx[7:0]), 32'h0);
      $display("test four wire done");
   endtask

   // Hang guard
   initial begin
      #2000000;
      fails++;
      $display("mismatch at %0t: timeout got %h expected %h", $time, 1'b1, 1'b0);
      stop_test();
   end

   // Main sequence
   initial begin
      rst_b = 1'b0;
      conv_ready = 1'b0;
      conv_data = 16'h0000;
      conv_status = 8'h00;
      drdy_route_dout = 1'b0;
      fails = 0;
      total_checks = 0;
      cyc(16);
      rst_b = 1'b1;
      cyc(4);
      t_reset();
      t_three_wire();
      t_append();
      t_four_wire();
      stop_test();
   end
endmodule // spi_wire_mode_status_append_tb

// File: logic/scfg_pkg.sv
// Package: constants and types of the serial configuration block
package scfg_pkg;
   // Register addresses carried in the low six bits of the command byte
   localparam logic [5:0] ADDR_STATUS = 6'h00;
   localparam logic [5:0] ADDR_CONTROL = 6'h01;
   localparam logic [5:0] ADDR_DATA = 6'h02;
   localparam logic [5:0] ADDR_FAULT = 6'h03;
   // Command byte fields
   localparam int CMD_BAD_BIT = 7;
   localparam int CMD_READ_BIT = 6;
   // Frame lengths in SCLK edges
   localparam logic [5:0] CMD_BITS = 6'h08;
   localparam logic [5:0] LEN_BYTE = 6'h10;
   localparam logic [5:0] LEN_WORD = 6'h18;
   localparam logic [5:0] LEN_WORD_STATUS = 6'h20;
   localparam logic [5:0] TX_TOP = 6'h1f;
   // Reset value and write mask of the control register
   localparam logic [15:0] CONTROL_RESET = 16'h0000;
   localparam logic [15:0] CONTROL_RO_MASK = 16'hff7f;
   // Fault flag positions
   localparam int FAULT_WRITE = 0;
   localparam int FAULT_READ = 1;
   localparam int FAULT_COUNT = 2;
   // Output release delay
   localparam int CLK_PERIOD_NS = 50;
   localparam int REL_SHORT_NS = 10;
   localparam int REL_LONG_NS = 100;
   localparam int REL_SHORT_RAW = REL_SHORT_NS / CLK_PERIOD_NS;
   localparam int REL_LONG_RAW = REL_LONG_NS / CLK_PERIOD_NS;
   localparam logic [1:0] REL_SHORT_CYC = (REL_SHORT_RAW < 1) ? 2'h1 : 2'(REL_SHORT_RAW);
   localparam logic [1:0] REL_LONG_CYC = (REL_LONG_RAW < 1) ? 2'h1 : 2'(REL_LONG_RAW);
   // Toggle events from the link domain
   localparam int EV_START = 0;
   localparam int EV_END = 1;
   localparam int EV_WRITE = 2;
   localparam int EV_RDDATA = 3;
   localparam int EV_WFAULT = 4;
   localparam int EV_RFAULT = 5;
   localparam int EV_RDFAULT = 6;
   localparam int EV_COUNT = 7;

   // Converter control register layout
   typedef struct packed {
      logic [1:0] spare;
      logic reference_level_select;
      logic output_release_delay;
      logic cont_read;
      logic status_append;
      logic chip_select_enable;
      logic int_ref_enable;
      logic reserved;
      logic [6:0] mode_bits;
   } scfg_ctrl_t;

   // Image read by the link domain
   typedef struct packed {
      scfg_ctrl_t ctrl;
      logic [15:0] data;
      logic [7:0] status;
      logic [7:0] fault;
   } scfg_snap_t;

   // Output release sequence
   typedef enum logic [1:0] {
      REL_IDLE = 2'b00,
      REL_WAIT = 2'b01,
      REL_DONE = 2'b11
   } scfg_rel_t;
endpackage

// File: logic/scfg_sync.sv
// Two-stage synchroniser for a group of independent levels
`timescale 1ns/1ns
module scfg_sync #(
   parameter int W = 1,
   parameter logic [W-1:0] INIT = '0
) (
   input wire logic clk_i,
   input wire logic rst_b,
   input wire logic [W-1:0] d,
   output logic [W-1:0] q
);
   logic [W-1:0] meta_reg;

   // First stage feeds only the second
   always_ff @(posedge clk_i or negedge rst_b) begin
      if (!rst_b) begin
         meta_reg <= INIT;
         q <= INIT;
      end else begin
         meta_reg <= d;
         q <= meta_reg;
      end
   end
endmodule // scfg_sync

// File: logic/scfg_top.sv
// Serial port of the converter: wire mode, status append, control register
// How it works
// - Status append bit set: data read sends 16-bit result then status byte.
// - Chip select enable 0: 3-wire mode, frame ends on final rising SCLK.
// - 3-wire read with ready on alert pin: output released after last edge.
// - Host holds chip select low to drive output; high always tristates it.
// - Chip select enable 1: 4-wire mode, interface reset on chip select rise.
// - 4-wire, ready routed to output pin: pin shows ready while select is low between frames, unless a read frame ended with select kept low.
// - 4-wire: output pin high impedance while chip select is high.
// - Write, read and clock count faults flagged only in 4-wire mode.
// - Internal reference enable turns reference on; level bit picks output level.
// - 3-wire release delay: one 50 ns clock when bit clear, 100 ns when set.
`timescale 1ns/1ns
module scfg_top (
   input wire logic clk,
   input wire logic rst_b,
   input wire logic sclk,
   input wire logic cs_b,
   input wire logic sdi,
   input wire logic conv_ready,
   input wire logic [15:0] conv_data,
   input wire logic [7:0] conv_status,
   input wire logic drdy_route_dout,
   output logic dout_o,
   output logic dout_oe,
   output logic drdy_alert_b,
   output logic [15:0] ctrl_o,
   output logic int_ref_on,
   output logic ref_level_low
);
   logic csen_sk;
   logic sk_rst_b;
   logic oe_rst_b;
   logic rel_reg;
   logic [5:0] bit_cnt_reg;
   logic [7:0] cmd_reg;
   logic [7:0] cmd_next;
   logic [15:0] sh_in_reg;
   logic [23:0] tx_word_reg;
   logic [15:0] wr_word_reg;
   logic [scfg_pkg::EV_COUNT-1:0] tg_reg;
   logic dout_bit_reg;
   logic data_oe_reg;
   logic last_edge;
   logic [5:0] frame_len;
   logic cmd_read;
   logic cmd_known;
   logic [4:0] tx_idx;
   scfg_pkg::scfg_snap_t snap_reg;

   // Wire mode bit brought into the link domain
   scfg_sync #(.W(1), .INIT(1'b0)) u_csen_sync (
      .clk_i(sclk),
      .rst_b(rst_b),
      .d(snap_reg.ctrl.chip_select_enable),
      .q(csen_sk)
   );
   // Frame state clears on chip select rise only in 4-wire mode
   assign sk_rst_b = rst_b & ~(cs_b & csen_sk);
   // Pin driver drops whenever select is high, in either mode
   assign oe_rst_b = rst_b & ~cs_b & ~rel_reg;

   assign cmd_next = {cmd_reg[6:0], sdi};
   assign cmd_read = cmd_reg[scfg_pkg::CMD_READ_BIT];

   // Frame length follows the addressed register
   always_comb begin
      cmd_known = ~cmd_reg[scfg_pkg::CMD_BAD_BIT];
      case (cmd_reg[5:0])
         scfg_pkg::ADDR_CONTROL: frame_len = scfg_pkg::LEN_WORD;
         scfg_pkg::ADDR_DATA: frame_len = snap_reg.ctrl.status_append ? scfg_pkg::LEN_WORD_STATUS
                                                          : scfg_pkg::LEN_WORD;
         scfg_pkg::ADDR_STATUS: frame_len = scfg_pkg::LEN_BYTE;
         scfg_pkg::ADDR_FAULT: frame_len = scfg_pkg::LEN_BYTE;
         default: begin
            frame_len = scfg_pkg::LEN_BYTE;
            cmd_known = 1'b0;
         end
      endcase
   end

   // Only the exact count closes a frame; the host keeps the count
   assign last_edge = (bit_cnt_reg >= scfg_pkg::CMD_BITS) &&
                      (bit_cnt_reg == frame_len - 6'h01);

   // Bit counter and shift-in; 3-wire frames restart on their final edge
   always_ff @(posedge sclk or negedge sk_rst_b) begin
      if (!sk_rst_b) begin
         bit_cnt_reg <= 6'h00;
         cmd_reg <= 8'h00;
         sh_in_reg <= 16'h0000;
      end else begin
         if (last_edge) begin
            bit_cnt_reg <= 6'h00;
         end else begin
            bit_cnt_reg <= bit_cnt_reg + 6'h01;
         end
         if (bit_cnt_reg < scfg_pkg::CMD_BITS) begin
            cmd_reg <= cmd_next;
         end else begin
            sh_in_reg <= {sh_in_reg[14:0], sdi};
         end
      end
   end

   // Read word loaded once the command byte is complete
   always_ff @(posedge sclk or negedge sk_rst_b) begin
      if (!sk_rst_b) begin
         tx_word_reg <= 24'h000000;
      end else if (bit_cnt_reg == scfg_pkg::CMD_BITS - 6'h01) begin
         case (cmd_next[5:0])
            scfg_pkg::ADDR_CONTROL: tx_word_reg <= {snap_reg.ctrl, 8'h00};
            scfg_pkg::ADDR_DATA: tx_word_reg <= {snap_reg.data, snap_reg.status};
            scfg_pkg::ADDR_STATUS: tx_word_reg <= {snap_reg.status, 16'h0000};
            scfg_pkg::ADDR_FAULT: tx_word_reg <= {snap_reg.fault, 16'h0000};
            default: tx_word_reg <= 24'h000000;
         endcase
      end
   end

   // Events to the system domain; toggles survive frame resets
   always_ff @(posedge sclk or negedge rst_b) begin
      if (!rst_b) begin
         tg_reg <= '0;
         wr_word_reg <= 16'h0000;
      end else begin
         if (bit_cnt_reg == 6'h00) begin
            tg_reg[scfg_pkg::EV_START] <= ~tg_reg[scfg_pkg::EV_START];
         end
         if (last_edge) begin
            tg_reg[scfg_pkg::EV_END] <= ~tg_reg[scfg_pkg::EV_END];
         end
         // Word held until the next write, long after the toggle is seen
         if (last_edge && !cmd_read && cmd_known &&
             cmd_reg[5:0] == scfg_pkg::ADDR_CONTROL) begin
            wr_word_reg <= {sh_in_reg[14:0], sdi};
            tg_reg[scfg_pkg::EV_WRITE] <= ~tg_reg[scfg_pkg::EV_WRITE];
         end
         if (bit_cnt_reg == scfg_pkg::CMD_BITS - 6'h01) begin
            if (cmd_next[scfg_pkg::CMD_READ_BIT] && cmd_next[5:0] == scfg_pkg::ADDR_DATA) begin
               tg_reg[scfg_pkg::EV_RDDATA] <= ~tg_reg[scfg_pkg::EV_RDDATA];
            end
            if (cmd_next[scfg_pkg::CMD_READ_BIT] && cmd_next[5:0] == scfg_pkg::ADDR_FAULT) begin
               tg_reg[scfg_pkg::EV_RDFAULT] <= ~tg_reg[scfg_pkg::EV_RDFAULT];
            end
            // Faults meaningful only with chip select in use
            if (csen_sk && !cmd_next[scfg_pkg::CMD_READ_BIT] &&
                (cmd_next[5:0] != scfg_pkg::ADDR_CONTROL || cmd_next[scfg_pkg::CMD_BAD_BIT])) begin
               tg_reg[scfg_pkg::EV_WFAULT] <= ~tg_reg[scfg_pkg::EV_WFAULT];
            end
            if (csen_sk && cmd_next[scfg_pkg::CMD_READ_BIT] &&
                (cmd_next[5:0] > scfg_pkg::ADDR_FAULT || cmd_next[scfg_pkg::CMD_BAD_BIT])) begin
               tg_reg[scfg_pkg::EV_RFAULT] <= ~tg_reg[scfg_pkg::EV_RFAULT];
            end
         end
      end
   end

   assign tx_idx = 5'(scfg_pkg::TX_TOP - bit_cnt_reg);
   // Data leaves on the falling edge so the host samples on the rising one
   always_ff @(negedge sclk or negedge oe_rst_b) begin
      if (!oe_rst_b) begin
         dout_bit_reg <= 1'b1;
         data_oe_reg <= 1'b0;
      end else if (bit_cnt_reg >= scfg_pkg::CMD_BITS && cmd_read) begin
         dout_bit_reg <= tx_word_reg[tx_idx];
         data_oe_reg <= 1'b1;
      end else if (bit_cnt_reg == 6'h00) begin
         data_oe_reg <= 1'b0;
      end
   end

   logic [scfg_pkg::EV_COUNT-1:0] tg_s;
   logic [scfg_pkg::EV_COUNT-1:0] tg_prev_reg;
   logic [scfg_pkg::EV_COUNT-1:0] ev;
   logic cs_s;
   logic cs_prev_reg;
   logic ab_reg;
   logic busy;
   logic drdy_b_reg;
   logic drdy_oe_reg;
   logic [2:0] fault_reg;
   logic [15:0] ctrl_reg;
   logic [15:0] data_reg;
   logic [7:0] status_reg;
   logic [1:0] rel_cnt_reg;
   scfg_pkg::scfg_rel_t rel_state_reg;
   scfg_pkg::scfg_ctrl_t ctrl_f;

   assign ctrl_f = scfg_pkg::scfg_ctrl_t'(ctrl_reg);
   scfg_sync #(.W(scfg_pkg::EV_COUNT), .INIT('0)) u_ev_sync (
      .clk_i(clk),
      .rst_b(rst_b),
      .d(tg_reg),
      .q(tg_s)
   );
   scfg_sync #(.W(1), .INIT(1'b1)) u_cs_sync (
      .clk_i(clk),
      .rst_b(rst_b),
      .d(cs_b),
      .q(cs_s)
   );
   assign ev = tg_s ^ tg_prev_reg;
   // Frame open unless closed normally or abandoned by select
   assign busy = tg_s[scfg_pkg::EV_START] ^ tg_s[scfg_pkg::EV_END] ^ ab_reg;

   // Edge history
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         tg_prev_reg <= '0;
         cs_prev_reg <= 1'b1;
      end else begin
         tg_prev_reg <= tg_s;
         cs_prev_reg <= cs_s;
      end
   end

   // Control register, written only by complete write frames
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         ctrl_reg <= scfg_pkg::CONTROL_RESET;
      end else if (ev[scfg_pkg::EV_WRITE]) begin
         ctrl_reg <= wr_word_reg & scfg_pkg::CONTROL_RO_MASK;
      end
   end

   // Result capture and ready flag; a new result beats the clear
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         data_reg <= 16'h0000;
         status_reg <= 8'h00;
         drdy_b_reg <= 1'b1;
      end else if (conv_ready) begin
         data_reg <= conv_data;
         status_reg <= conv_status;
         drdy_b_reg <= 1'b0;
      end else if (ev[scfg_pkg::EV_RDDATA]) begin
         drdy_b_reg <= 1'b1;
      end
   end

   // Fault flags clear on read; a fault in the same cycle survives
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         fault_reg <= 3'h0;
         ab_reg <= 1'b0;
      end else begin
         if (ev[scfg_pkg::EV_RDFAULT]) begin
            fault_reg <= 3'h0;
         end
         if (ev[scfg_pkg::EV_WFAULT]) begin
            fault_reg[scfg_pkg::FAULT_WRITE] <= 1'b1;
         end
         if (ev[scfg_pkg::EV_RFAULT]) begin
            fault_reg[scfg_pkg::FAULT_READ] <= 1'b1;
         end
         // Select rose mid-frame: wrong clock count
         if (cs_s && !cs_prev_reg && busy && ctrl_f.chip_select_enable) begin
            fault_reg[scfg_pkg::FAULT_COUNT] <= 1'b1;
            ab_reg <= ~ab_reg;
         end
      end
   end

   // Image frozen while a frame runs so the link sees stable words
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         snap_reg <= '0;
      end else if (!busy) begin
         snap_reg <= {ctrl_reg, data_reg, status_reg, 5'h00, fault_reg};
      end
   end

   // 3-wire release after the final edge; sync latency adds two cycles
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         rel_state_reg <= scfg_pkg::REL_IDLE;
         rel_cnt_reg <= 2'h0;
         rel_reg <= 1'b0;
      end else begin
         case (rel_state_reg)
            scfg_pkg::REL_IDLE: begin
               rel_reg <= 1'b0;
               if (ev[scfg_pkg::EV_END] && !ctrl_f.chip_select_enable &&
                   !drdy_route_dout) begin
                  rel_state_reg <= scfg_pkg::REL_WAIT;
                  rel_cnt_reg <= ctrl_f.output_release_delay ? scfg_pkg::REL_LONG_CYC
                                                             : scfg_pkg::REL_SHORT_CYC;
               end
            end
            scfg_pkg::REL_WAIT: begin
               if (rel_cnt_reg <= 2'h1) begin
                  rel_state_reg <= scfg_pkg::REL_DONE;
                  rel_reg <= 1'b1;
               end else begin
                  rel_cnt_reg <= rel_cnt_reg - 2'h1;
               end
            end
            scfg_pkg::REL_DONE: begin
               if (ev[scfg_pkg::EV_START]) begin
                  rel_state_reg <= scfg_pkg::REL_IDLE;
                  rel_reg <= 1'b0;
               end
            end
            default: begin
               rel_state_reg <= scfg_pkg::REL_IDLE;
               rel_reg <= 1'b0;
            end
         endcase
      end
   end

   // Ready indication takes the pin between frames while select is low and no read data is still driven
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         drdy_oe_reg <= 1'b0;
         drdy_alert_b <= 1'b1;
      end else begin
         drdy_oe_reg <= drdy_route_dout & ~cs_s & ~busy;
         drdy_alert_b <= drdy_route_dout | drdy_b_reg;
      end
   end

   // Analog and converter controls
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         ctrl_o <= scfg_pkg::CONTROL_RESET;
         int_ref_on <= 1'b0;
         ref_level_low <= 1'b0;
      end else begin
         ctrl_o <= ctrl_reg;
         int_ref_on <= ctrl_f.int_ref_enable;
         ref_level_low <= ctrl_f.int_ref_enable & ctrl_f.reference_level_select;
      end
   end

   // Pin mux; raw select gates the ready driver, whose flop lags the synchroniser
   assign dout_o = data_oe_reg ? dout_bit_reg : drdy_b_reg;
   assign dout_oe = data_oe_reg | (drdy_oe_reg & ~cs_b);
endmodule // scfg_top
